//--- verilog/ccsr_core.sv
// Core execute stage, working register and data-mapped core registers
//
// Function
// - Instructions are 12 bits fetched in one cycle; data words are 8 bits.
// - Fetch of next instruction overlaps execute; branches cost one extra cycle.
// - Program bus and data memory are separate and used in the same cycle.
// - Core registers other than W, options and direction, PC low byte included, sit in data memory.
// - Eight-bit two's complement add, subtract, shift and logic unit.
// - Working register is 8 bits and has no data address.
// - On subtract, carry and nibble bit mean no borrow.
// - Address 00h redirects through the pointer at 04h; no storage.
// - Address 02h shows only PC bits 7:0.
// - Flag-affecting ops on status replace written flags with results.
// - Watchdog-expired and sleep-entered bits ignore instruction writes.
// - Clearing status clears top three bits, keeps read-only bits, sets zero.
// - Bit 7 set on pin-change wake reset, cleared by other resets.
// - Bit 5 selects program page one (200h-3FFh) or zero.
// - Add sets nibble carry when low nibble carries out.
// - Subtract sets nibble carry when low nibble does not borrow.
// - Rotates load carry with LSB going right, MSB going left.
// - Power-on reset differs from master, watchdog and wake resets.
// - Unimplemented bits read as zero.
// - Power-on sets status bits 7:3 to 00011.
// - Every reset clears the page-select bit.
// - Jump takes PC bit 9 from status bit 5, bits 8:0 from the word.
// - Reset sets PC to the last location, then it rolls to zero.
`timescale 1ns/1ps
`default_nettype none

module ccsr_core (
    // Clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        ce_in,
    input  wire logic [1:0]  reset_class_in,
    // Program bus
    input  wire logic [11:0] instr_in,
    output logic      [9:0]  pc_out,
    // Device events
    input  wire logic        wdt_timeout_in,
    output logic             sleep_out,
    output logic             wdt_clear_out,
    // General pins
    input  wire logic [5:0]  pin_in,
    output logic      [5:0]  pin_out,
    output logic      [5:0]  pin_oe_out,
    // Register views
    output logic      [7:0]  w_out,
    output logic      [7:0]  status_out,
    output logic      [7:0]  options_out,
    output logic      [7:0]  trim_out,
    output logic      [7:0]  timer_out
);

    // ************************************************
    // State
    // ************************************************
    logic [11:0] instr;
    logic [9:0]  pc;
    logic [7:0]  w;
    logic [7:0]  status;
    logic [7:0]  pointer;
    logic [7:0]  timer;
    logic [7:0]  trim;
    logic [5:0]  pin_latch;
    logic [5:0]  direction;
    logic [7:0]  options;
    logic        asleep;
    logic        wdt_clr;
    logic [7:0]  file_mem [0:31];

    // Nine-bit sum with carry in
    function automatic logic [8:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        add8 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction

    // ************************************************
    // Instruction decode
    // ************************************************
    wire [3:0] op       = instr[11:8];
    wire       is_goto  = (instr[11:9] == ccsr_pkg::OP_GOTO);
    wire       to_file  = instr[5];
    wire [2:0] bit_sel  = instr[7:5];
    wire [7:0] literal  = instr[7:0];
    wire [4:0] f_addr   = instr[4:0];
    wire       is_spec  = (op == ccsr_pkg::OP_SPECIAL);
    wire       op_sleep = is_spec && (literal == ccsr_pkg::SP_SLEEP);
    wire       op_wclr  = is_spec && (literal == ccsr_pkg::SP_WDTCLR);
    wire       op_opt   = is_spec && (literal == ccsr_pkg::SP_OPTION);
    wire       op_dir   = is_spec && (literal == ccsr_pkg::SP_DIR);

    // Indirect redirect through the pointer
    wire [4:0] eff_addr = (f_addr == ccsr_pkg::ADDR_INDIRECT) ? pointer[4:0] : f_addr;

    // ************************************************
    // Data-memory read selection
    // ************************************************
    wire [7:0] rd_data =
        (eff_addr == ccsr_pkg::ADDR_INDIRECT) ? ccsr_pkg::ZERO8 :
        (eff_addr == ccsr_pkg::ADDR_TIMER)    ? timer :
        (eff_addr == ccsr_pkg::ADDR_PCL)      ? pc[7:0] :
        (eff_addr == ccsr_pkg::ADDR_STATUS)   ? status :
        (eff_addr == ccsr_pkg::ADDR_POINTER)  ? pointer :
        (eff_addr == ccsr_pkg::ADDR_TRIM)     ? trim :
        (eff_addr == ccsr_pkg::ADDR_PINS)     ? {2'b00, pin_in} :
        file_mem[eff_addr];

    // Adder taps for add and subtract
    wire [8:0] sum_add = add8(rd_data, w, 1'b0);
    wire [8:0] sum_sub = add8(rd_data, ~w, 1'b1);
    wire [8:0] nib_add = add8({4'h0, rd_data[3:0]}, {4'h0, w[3:0]}, 1'b0);
    wire [8:0] nib_sub = add8({4'h0, rd_data[3:0]}, {4'h0, ~w[3:0]}, 1'b1);

    // ************************************************
    // Arithmetic unit and destination select
    // ************************************************
    logic [7:0] alu_res;
    logic       new_c;
    logic       new_dc;
    logic       aff_z;
    logic       aff_dc;
    logic       aff_c;
    logic       wr_file;
    logic       wr_w;

    always_comb begin
        alu_res = rd_data;
        new_c   = status[ccsr_pkg::ST_C];
        new_dc  = status[ccsr_pkg::ST_DC];
        aff_z   = 1'b0;
        aff_dc  = 1'b0;
        aff_c   = 1'b0;
        wr_file = 1'b0;
        wr_w    = 1'b0;
        case (op)
            ccsr_pkg::OP_MOVE_TO_FILE_OP: begin
                alu_res = w;
                wr_file = 1'b1;
            end
            ccsr_pkg::OP_CLEAR_FILE_OP: begin
                alu_res = ccsr_pkg::ZERO8;
                aff_z   = 1'b1;
                wr_file = to_file;
                wr_w    = !to_file;
            end
            ccsr_pkg::OP_ADD: begin
                alu_res = sum_add[7:0];
                new_c   = sum_add[8];
                new_dc  = nib_add[4];
                {aff_z, aff_dc, aff_c} = 3'b111;
                wr_file = to_file;
                wr_w    = !to_file;
            end
            ccsr_pkg::OP_SUB: begin
                alu_res = sum_sub[7:0];
                new_c   = sum_sub[8];
                new_dc  = nib_sub[4];
                {aff_z, aff_dc, aff_c} = 3'b111;
                wr_file = to_file;
                wr_w    = !to_file;
            end
            ccsr_pkg::OP_AND, ccsr_pkg::OP_IOR, ccsr_pkg::OP_XOR: begin
                alu_res = (op == ccsr_pkg::OP_AND) ? (rd_data & w) :
                          (op == ccsr_pkg::OP_IOR) ? (rd_data | w) : (rd_data ^ w);
                aff_z   = 1'b1;
                wr_file = to_file;
                wr_w    = !to_file;
            end
            ccsr_pkg::OP_RLF: begin
                alu_res = {rd_data[6:0], status[ccsr_pkg::ST_C]};
                new_c   = rd_data[7];
                aff_c   = 1'b1;
                wr_file = to_file;
                wr_w    = !to_file;
            end
            ccsr_pkg::OP_RRF: begin
                alu_res = {status[ccsr_pkg::ST_C], rd_data[7:1]};
                new_c   = rd_data[0];
                aff_c   = 1'b1;
                wr_file = to_file;
                wr_w    = !to_file;
            end
            ccsr_pkg::OP_MOVF: begin
                aff_z   = 1'b1;
                wr_file = to_file;
                wr_w    = !to_file;
            end
            ccsr_pkg::OP_BCF: begin
                alu_res = rd_data & ~(8'h01 << bit_sel);
                wr_file = 1'b1;
            end
            ccsr_pkg::OP_BSF: begin
                alu_res = rd_data | (8'h01 << bit_sel);
                wr_file = 1'b1;
            end
            ccsr_pkg::OP_MOVLW: begin
                alu_res = literal;
                wr_w    = 1'b1;
            end
            default: begin
                alu_res = rd_data;
            end
        endcase
    end

    // Result zero test and flag merge
    wire       res_zero = (alu_res == ccsr_pkg::ZERO8);
    wire       aff_any  = aff_z | aff_dc | aff_c;
    wire [2:0] flags_old = status[2:0];
    wire [2:0] flags_new = {aff_z ? res_zero : flags_old[2],
                            aff_dc ? new_dc : flags_old[1],
                            aff_c ? new_c : flags_old[0]};

    // Status write target selection
    wire       hit_status = wr_file && (eff_addr == ccsr_pkg::ADDR_STATUS);
    wire [2:0] st_low     = (hit_status && !aff_any) ? alu_res[2:0] : flags_new;

    // ************************************************
    // Branch and program counter
    // ************************************************
    wire       hit_pcl   = wr_file && (eff_addr == ccsr_pkg::ADDR_PCL);
    wire       branch    = !asleep && (is_goto || hit_pcl);
    wire [9:0] goto_pc   = {status[ccsr_pkg::ST_PAGE], instr[8:0]};
    wire [9:0] pcl_pc    = {status[ccsr_pkg::ST_PAGE], 1'b0, alu_res};
    wire [9:0] next_pc   = is_goto ? goto_pc : hit_pcl ? pcl_pc : pc + 10'h001;
    wire       run       = ce_in && !asleep;
    wire [1:0] rst_class = reset_class_in;

    // ************************************************
    // Fetch stage and program counter
    // ************************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pc    <= ccsr_pkg::PC_RESET;
            instr <= ccsr_pkg::INSTR_NOP;
        end else if (run) begin
            pc    <= next_pc;
            instr <= branch ? ccsr_pkg::INSTR_NOP : instr_in;
        end
    end

    // ************************************************
    // Working register and general file
    // ************************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            if (rst_class == ccsr_pkg::CCSR_RST_POWER) begin
                w <= ccsr_pkg::ZERO8;
            end
        end else if (run) begin
            if (wr_w) begin
                w <= alu_res;
            end
            if (wr_file && eff_addr > ccsr_pkg::ADDR_PINS) begin
                file_mem[eff_addr] <= alu_res;
            end
        end
    end

    // ************************************************
    // Mapped core registers, direction and options
    // ************************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            direction <= ccsr_pkg::DIR_RESET;
            options   <= ccsr_pkg::OPT_RESET;
            if (rst_class == ccsr_pkg::CCSR_RST_POWER) begin
                pointer   <= ccsr_pkg::ZERO8;
                timer     <= ccsr_pkg::ZERO8;
                trim      <= ccsr_pkg::TRIM_POR;
                pin_latch <= 6'h00;
            end
        end else if (run) begin
            if (wr_file && eff_addr == ccsr_pkg::ADDR_POINTER) begin
                pointer <= alu_res;
            end
            if (wr_file && eff_addr == ccsr_pkg::ADDR_TIMER) begin
                timer <= alu_res;
            end
            if (wr_file && eff_addr == ccsr_pkg::ADDR_TRIM) begin
                trim <= alu_res;
            end
            if (wr_file && eff_addr == ccsr_pkg::ADDR_PINS) begin
                pin_latch <= alu_res[5:0];
            end
            if (op_dir) begin
                direction <= w[5:0];
            end
            if (op_opt) begin
                options <= w;
            end
        end
    end

    // ************************************************
    // Status register and reset cause
    // ************************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            if (rst_class == ccsr_pkg::CCSR_RST_POWER) begin
                status <= ccsr_pkg::STATUS_POR;
            end else begin
                status[ccsr_pkg::ST_WAKE] <= (rst_class == ccsr_pkg::CCSR_RST_WAKE);
                status[ccsr_pkg::ST_RSV]  <= 1'b0;
                status[ccsr_pkg::ST_PAGE] <= 1'b0;
                if (rst_class == ccsr_pkg::CCSR_RST_WATCHDOG) begin
                    status[ccsr_pkg::ST_TO] <= 1'b0;
                end
            end
        end else if (ce_in) begin
            if (run) begin
                status[2:0] <= st_low;
                if (hit_status) begin
                    status[ccsr_pkg::ST_WAKE] <= alu_res[ccsr_pkg::ST_WAKE];
                    status[ccsr_pkg::ST_PAGE] <= alu_res[ccsr_pkg::ST_PAGE];
                end
                if (op_sleep) begin
                    status[ccsr_pkg::ST_TO] <= 1'b1;
                    status[ccsr_pkg::ST_PD] <= 1'b0;
                end
                if (op_wclr) begin
                    status[ccsr_pkg::ST_TO] <= 1'b1;
                    status[ccsr_pkg::ST_PD] <= 1'b1;
                end
            end
            if (wdt_timeout_in) begin
                status[ccsr_pkg::ST_TO] <= 1'b0;
            end
        end
    end

    // ************************************************
    // Sleep state and watchdog clear pulse
    // ************************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            asleep  <= 1'b0;
            wdt_clr <= 1'b0;
        end else if (ce_in) begin
            wdt_clr <= run && op_wclr;
            if (run && op_sleep) begin
                asleep <= 1'b1;
            end
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign pc_out        = pc;
    assign sleep_out     = asleep;
    assign wdt_clear_out = wdt_clr;
    assign pin_out       = pin_latch;
    assign pin_oe_out    = ~direction;
    assign w_out         = w;
    assign status_out    = {status[7], 1'b0, status[5:0]};
    assign options_out   = options;
    assign trim_out      = trim;
    assign timer_out     = timer;

endmodule // ccsr_core

`default_nettype wire

//--- verilog/ccsr_pkg.sv
// Constants, opcodes and reset classes of the core register set
package ccsr_pkg;

    // ************************************************
    // Widths
    // ************************************************
    localparam int INSTR_W = 12;
    localparam int DATA_W  = 8;
    localparam int PC_W    = 10;
    localparam int ADDR_W  = 5;
    localparam int PIN_W   = 6;
    localparam int FILE_N  = 32;

    // ************************************************
    // Data-memory map
    // ************************************************
    localparam logic [4:0] ADDR_INDIRECT = 5'h00;
    localparam logic [4:0] ADDR_TIMER    = 5'h01;
    localparam logic [4:0] ADDR_PCL      = 5'h02;
    localparam logic [4:0] ADDR_STATUS   = 5'h03;
    localparam logic [4:0] ADDR_POINTER  = 5'h04;
    localparam logic [4:0] ADDR_TRIM     = 5'h05;
    localparam logic [4:0] ADDR_PINS     = 5'h06;

    // ************************************************
    // Status bit positions
    // ************************************************
    localparam int ST_WAKE = 7;
    localparam int ST_RSV  = 6;
    localparam int ST_PAGE = 5;
    localparam int ST_TO   = 4;
    localparam int ST_PD   = 3;
    localparam int ST_Z    = 2;
    localparam int ST_DC   = 1;
    localparam int ST_C    = 0;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [9:0] PC_RESET   = 10'h3ff;
    localparam logic [5:0] DIR_RESET  = 6'h3f;
    localparam logic [7:0] OPT_RESET  = 8'hff;
    localparam logic [7:0] TRIM_POR   = 8'h80;
    localparam logic [7:0] ZERO8      = 8'h00;

    // ************************************************
    // Instruction fields and opcodes (bits 11:8; jump bits 11:9, special codes bits 7:0)
    // ************************************************
    localparam logic [3:0] OP_SPECIAL = 4'h0;
    localparam logic [3:0] OP_MOVE_TO_FILE_OP   = 4'h1;
    localparam logic [3:0] OP_CLEAR_FILE_OP    = 4'h2;
    localparam logic [3:0] OP_ADD     = 4'h3;
    localparam logic [3:0] OP_SUB     = 4'h4;
    localparam logic [3:0] OP_AND     = 4'h5;
    localparam logic [3:0] OP_IOR     = 4'h6;
    localparam logic [3:0] OP_XOR     = 4'h7;
    localparam logic [3:0] OP_RLF     = 4'h8;
    localparam logic [3:0] OP_RRF     = 4'h9;
    localparam logic [3:0] OP_MOVF    = 4'ha;
    localparam logic [3:0] OP_BCF     = 4'hb;
    localparam logic [3:0] OP_BSF     = 4'hc;
    localparam logic [3:0] OP_MOVLW   = 4'hd;
    localparam logic [2:0] OP_GOTO    = 3'h7;
    localparam logic [7:0] SP_NOP     = 8'h00;
    localparam logic [7:0] SP_OPTION  = 8'h01;
    localparam logic [7:0] SP_SLEEP   = 8'h02;
    localparam logic [7:0] SP_WDTCLR  = 8'h03;
    localparam logic [7:0] SP_DIR     = 8'h04;
    localparam logic [11:0] INSTR_NOP = 12'h000;

    // ************************************************
    // Reset classes
    // ************************************************
    typedef enum logic [1:0] {
        CCSR_RST_POWER,
        CCSR_RST_MASTER,
        CCSR_RST_WATCHDOG,
        CCSR_RST_WAKE
    } ccsr_reset_t;

endpackage

//--- dv/ccsr_core_asserts.sv
// Port-level checker for the core register set
`timescale 1ns/1ps
`default_nettype none

module ccsr_asserts (
    // Clock, reset, enable
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        ce_in,
    input wire logic [1:0]  reset_class_in,
    // Program bus and events
    input wire logic [11:0] instr_in,
    input wire logic [9:0]  pc_out,
    input wire logic        wdt_timeout_in,
    input wire logic        sleep_out,
    input wire logic        wdt_clear_out,
    // Register views
    input wire logic [7:0]  w_out,
    input wire logic [7:0]  status_out
);
    default clocking cb @(posedge clk_in); endclocking

    // ****************************************
    // Reset values
    // ****************************************
    a_reset_pc: assert property (!resetn_in |=> pc_out == 10'h3ff)
        else $error("pc not at last location after reset");
    a_por_status: assert property (!resetn_in && reset_class_in == 2'd0 |=> status_out[7:3] == 5'h03)
        else $error("status top bits wrong after power-on");
    a_reset_page_wake: assert property (!resetn_in |=>
        !status_out[5] && status_out[7] == ($past(reset_class_in) == 2'd3))
        else $error("page or wake bit wrong after reset");
    a_wd_reset: assert property (!resetn_in && reset_class_in == 2'd2 |=> !status_out[4])
        else $error("expired flag set after watchdog reset");

    // ****************************************
    // Running behaviour
    // ****************************************
    a_bit6_zero: assert property (disable iff (!resetn_in) status_out[6] == 1'b0)
        else $error("unimplemented status bit reads one");
    a_timeout_clr: assert property (disable iff (!resetn_in) ce_in && wdt_timeout_in |=> !status_out[4])
        else $error("expired flag not cleared by time-out");
    a_sleep_flags: assert property (disable iff (!resetn_in)
        $rose(sleep_out) && !$past(wdt_timeout_in) |-> status_out[4:3] == 2'b10)
        else $error("flags wrong on sleep entry");
    a_wdt_clear: assert property (disable iff (!resetn_in)
        wdt_clear_out && !$past(wdt_timeout_in) |-> status_out[4:3] == 2'b11)
        else $error("flags wrong after watchdog clear");
    a_sleep_hold: assert property (disable iff (!resetn_in)
        sleep_out |=> sleep_out && $stable(pc_out) && $stable(w_out))
        else $error("core advanced while asleep");
    a_ce_freeze: assert property (disable iff (!resetn_in) !ce_in |=> $stable(pc_out) && $stable(w_out))
        else $error("core advanced with enable low");

    // Jump fetched after a plain word, then executed on the next running edge
    sequence s_goto_fetch;
        ce_in && !sleep_out && instr_in[11:9] == 3'b111 && $past(ce_in) && $past(resetn_in)
            && $past(instr_in[11:9]) != 3'b111 && $past(instr_in[4:0]) != 5'h02
            && $past(instr_in[4:0]) != 5'h00;
    endsequence
    sequence s_exec_run;
        ce_in && !sleep_out;
    endsequence
    a_goto_target: assert property (disable iff (!resetn_in) s_goto_fetch ##1 s_exec_run |=>
        pc_out == {$past(status_out[5]), $past(instr_in[8:0], 2)}) else $error("jump target wrong");
endmodule // ccsr_asserts

bind ccsr_core ccsr_asserts chk_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .reset_class_in(reset_class_in), .instr_in(instr_in), .pc_out(pc_out), .wdt_timeout_in(wdt_timeout_in),
    .sleep_out(sleep_out), .wdt_clear_out(wdt_clear_out), .w_out(w_out), .status_out(status_out));

`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the core register set
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    logic        clk_in, resetn_in, ce_in, wdt_timeout_in;
    logic [1:0]  reset_class_in;
    logic [11:0] instr_in;
    logic [5:0]  pin_in, pin_out, pin_oe_out;
    logic [9:0]  pc_out;
    logic        sleep_out, wdt_clear_out;
    logic [7:0]  w_out, status_out, options_out, trim_out, timer_out;
    int          fail_count = 0;
    int          tests_run = 0;
    int          seed = 32'hc322ff4e;
    logic [7:0]  a, b, r;
    logic [2:0]  fl;
    logic [2:0]  s;
    logic [2:0]  sel_q[$];
    logic [11:0] exp_q[$];
    string       names[7] = '{"w_out", "status_out", "pc_out", "pins", "options_out", "trim_out",
                              "timer_out"};
    event        look;

    ccsr_core dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .reset_class_in(reset_class_in),
        .instr_in(instr_in), .pc_out(pc_out), .wdt_timeout_in(wdt_timeout_in), .sleep_out(sleep_out),
        .wdt_clear_out(wdt_clear_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .w_out(w_out), .status_out(status_out), .options_out(options_out), .trim_out(trim_out),
        .timer_out(timer_out));

    // Clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic note(input logic [2:0] sel, input logic [11:0] exp);
        sel_q.push_back(sel);
        exp_q.push_back(exp);
    endtask

    task automatic issue(input logic [11:0] word);
        @(posedge clk_in);
        instr_in <= word;
    endtask

    // Two fill words let the last real word execute
    task automatic settle;
        issue(12'h000);
        issue(12'h000);
        @(negedge clk_in);
    endtask

    task automatic do_reset(input logic [1:0] cls);
        @(posedge clk_in);
        resetn_in      <= 1'b0;
        reset_class_in <= cls;
        instr_in       <= 12'h000;
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(negedge clk_in);
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compare queued expectations with the live outputs
    initial begin
        forever begin
            @(look);
            while (sel_q.size() > 0) begin
                s = sel_q.pop_front();
                check(names[s], s == 3'd0 ? {4'h0, w_out} : s == 3'd1 ? {4'h0, status_out} :
                      s == 3'd2 ? {2'h0, pc_out} : s == 3'd3 ? {pin_oe_out, pin_out} :
                      s == 3'd4 ? {4'h0, options_out} : s == 3'd5 ? {4'h0, trim_out} :
                      {4'h0, timer_out}, exp_q.pop_front());
            end
        end
    end

    // Watchdog on a hung run
    initial begin
        #100000;
        fail_count++;
        close_out();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        resetn_in = 1'b0; ce_in = 1'b1; reset_class_in = 2'd0;
        instr_in = 12'h000; wdt_timeout_in = 1'b0; pin_in = 6'h00;
        do_reset(2'd0);
        note(1, 12'h018);
        note(2, 12'h3ff);
        note(3, 12'h000);
        note(4, 12'h0ff);
        note(5, 12'h080);
        note(6, 12'h000);
        ->look;
        // Random add, subtract and rotates through file 07h
        for (int i = 0; i < 8; i++) begin
            a = 8'($random(seed));
            b = 8'($random(seed));
            issue({4'hd, a}); issue(12'h127); issue({4'hd, b}); issue(12'h307); settle();
            r = a + b;
            note(0, {4'h0, r});
            note(1, {4'h0, 5'h03, r == 8'h00, (a[3:0] + b[3:0]) > 15, (a + b) > 255});
            ->look;
            issue({4'hd, b}); issue(12'h407); settle();
            r = a - b;
            fl = {r == 8'h00, a[3:0] >= b[3:0], a >= b};
            note(0, {4'h0, r});
            note(1, {4'h0, 5'h03, fl});
            ->look;
            issue(12'h807); settle();
            note(0, {4'h0, a[6:0], fl[0]});
            ->look;
            issue(12'h907); settle();
            note(0, {4'h0, a[7], a[7:1]});
            fl = {fl[2:1], a[0]};
            note(1, {4'h0, 5'h03, fl});
            ->look;
        end
        // Indirect port, pin read, pin latch and direction
        @(posedge clk_in);
        pin_in <= 6'($random(seed));
        issue(12'hd08); issue(12'h124); issue(12'hd5a); issue(12'h120); issue(12'ha08); settle();
        note(0, 12'h05a);
        ->look;
        issue(12'ha06); settle();
        note(0, {6'h00, pin_in});
        ->look;
        issue(12'hd15); issue(12'h126); issue(12'hd0f); issue(12'h004); settle();
        note(3, {6'h30, 6'h15});
        ->look;
        // Timer, trim and option registers loaded from W
        issue(12'hd3c); issue(12'h121); issue(12'h125); issue(12'h001); settle();
        note(4, 12'h03c);
        note(5, 12'h03c);
        note(6, 12'h03c);
        ->look;
        // Clearing status keeps the two read-only bits and sets zero
        issue(12'h223); settle();
        note(1, {4'h0, 5'h03, 1'b1, fl[1:0]});
        ->look;
        // Page bit steers the jump, then the enable freezes the core
        issue(12'hca3); issue(12'hf23); issue(12'h000);
        @(posedge clk_in);
        ce_in <= 1'b0;
        @(negedge clk_in);
        note(2, 12'h323);
        ->look;
        repeat (3) @(posedge clk_in);
        ce_in <= 1'b1;
        // Non power-on reset classes
        for (int c = 1; c < 4; c++) begin
            do_reset(2'(c));
            note(1, {4'h0, c == 3, 2'b00, c == 1, 2'b11, fl[1:0]});
            ->look;
        end
        // Watchdog clear, sleep, then a time-out while asleep
        issue(12'h003); settle();
        note(1, {4'h0, 5'b10011, 1'b1, fl[1:0]});
        ->look;
        issue(12'h002); settle();
        note(1, {4'h0, 5'b10010, 1'b1, fl[1:0]});
        ->look;
        @(posedge clk_in);
        wdt_timeout_in <= 1'b1;
        @(posedge clk_in);
        wdt_timeout_in <= 1'b0;
        @(negedge clk_in);
        note(1, {4'h0, 5'b10000, 1'b1, fl[1:0]});
        ->look;
        @(posedge clk_in);
        close_out();
    end
endmodule // tb

`default_nettype wire
